// file: pin_mux_pkg.sv
// pin_mux_pkg: shared types and constants of the external bus pin mux
// assumes one system clock domain plus one link clock for the sdram side
package pin_mux_pkg;

	localparam int DATA_W   = 16;             // shared data pins
	localparam int ADDR_W   = 24;             // shared address pins
	localparam int SD_ADDR_W = 13;            // sdram controller address
	localparam int NUM_CS   = 4;              // chip select pins
	localparam int BANK_W   = 2;              // sdram bank select bits

	// pin positions of the sdram address fields on the shared address bus
	localparam int SD_LO_PIN_LSB = 2;         // pins 11..2 carry sdram 9..0
	localparam int SD_LO_PIN_MSB = 11;
	localparam int SD_LO_BITS    = 10;
	localparam int SD_A10_BIT    = 10;        // sdram bit on its own pin
	localparam int SD_HI_PIN_LSB = 13;        // pins 14..13 carry sdram 12..11
	localparam int SD_HI_PIN_MSB = 14;
	localparam int SD_HI_BIT_LSB = 11;
	localparam int SD_HI_BITS    = 2;
	localparam int CS_SHARED     = 1;         // the chip select sdram may own

	// idle levels of the active low strobes and selects
	localparam logic [NUM_CS-1:0] CS_IDLE     = 4'hF;
	localparam logic              STROBE_IDLE = 1'h1;
	localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;
	localparam logic [ADDR_W-1:0] ADDR_RESET  = 24'h000000;

	// word the static memory controller presents while it requests
	typedef struct packed {
		logic [NUM_CS-1:0] cs_n;              // chip selects, low active
		logic [ADDR_W-1:0] addr;              // full static address
		logic              wr0_n;             // write 0 / write enable
		logic              wr1_n;             // write 1 / upper byte select
		logic              rd_n;              // read / output enable
		logic [DATA_W-1:0] wdata;             // write data
		logic              drive;             // drive data pins
	} static_word_t;

	// word the sdram controller presents while it requests
	typedef struct packed {
		logic                 cs_n;           // sdram chip select
		logic [SD_ADDR_W-1:0] addr;           // row / column address
		logic [BANK_W-1:0]    bank;           // bank select
		logic                 ras_n;          // row strobe
		logic                 cas_n;          // column strobe
		logic                 we_n;           // sdram write enable
		logic                 cke;            // clock enable, high active
		logic                 mask1_n;        // byte mask 1
		logic [DATA_W-1:0]    wdata;          // write data
		logic                 drive;          // drive data pins
		logic                 refresh;        // command needs no shared pins
	} sdram_word_t;

	// everything the mux drives onto the pins
	typedef struct packed {
		logic [NUM_CS-1:0] cs_n;
		logic [ADDR_W-1:0] addr;
		logic              sd_a10;
		logic              wr0_n;
		logic              wr1_n;
		logic              rd_n;
		logic [BANK_W-1:0] bank;
		logic              ras_n;
		logic              cas_n;
		logic              we_n;
		logic              cke;
		logic [DATA_W-1:0] dout;
		logic              dout_oe_n;
	} pin_out_t;

	// owner of the shared pins
	typedef enum logic [2:0] {
		OWN_NONE   = 3'h1,
		OWN_STATIC = 3'h2,
		OWN_SDRAM  = 3'h4
	} owner_t;

	localparam pin_out_t PINS_RESET = '{
		cs_n: CS_IDLE, addr: ADDR_RESET, sd_a10: 1'h0,
		wr0_n: STROBE_IDLE, wr1_n: STROBE_IDLE, rd_n: STROBE_IDLE,
		bank: 2'h0, ras_n: STROBE_IDLE, cas_n: STROBE_IDLE,
		we_n: STROBE_IDLE, cke: 1'h0, dout: DATA_RESET,
		dout_oe_n: 1'h1};

endpackage : pin_mux_pkg

// file: external_bus_pin_mux.sv
// external_bus_pin_mux: shares the external bus pins between the static
// memory controller (system clock) and the sdram controller (link clock)
// assumes both controllers hold their request word stable while requesting
// and drop the request only to end an access
//
// Overview of operation
// RULE_01: four static selects, one usable by sdram
// RULE_02: select 1 routed to sdram or static
// RULE_03: selects 0, 2, 3 static only
// RULE_04: 16 data pins, 24 address pins
// RULE_05: up to five external devices addressed; the mux selects at most four, sdram taking select 1
// RULE_06: routing follows the controller owning access
// RULE_07: pins 11..2: sdram 9..0 or static
// RULE_08: dedicated pin carries sdram address 10
// RULE_09: pins 14..13: sdram 12..11 or static
// RULE_10: pins 12, 23..15 static only
// RULE_11: shared pin: sdram mask 1 or write 1
// RULE_12: all data pins shared bit for bit
// RULE_13: selects and strobes active low
// RULE_14: sdram clock enable active high
// RULE_15: wait input is active low
// RULE_16: sdram write, row, column strobes low
// RULE_17: two bank select outputs from sdram
// RULE_18: shared lines held stable while idle
// RULE_19: refresh never delays static accesses
// RULE_20: one owner at a time, access completes
`timescale 1ns/10ps
`default_nettype none

module external_bus_pin_mux (
	input  wire logic                           clock,        // system clock
	input  wire logic                           rst,          // sync reset
	input  wire logic                           link_clock,   // sdram clock
	input  wire logic                           cs1_to_sdram, // select 1 owner
	// static memory controller side
	input  wire logic                           st_req,       // access request
	input  wire pin_mux_pkg::static_word_t      st_word,      // pin word
	output logic                                st_grant,     // pins owned
	output logic [pin_mux_pkg::DATA_W-1:0]      st_rdata,     // read data
	output logic                                st_wait_n,    // wait, synced
	// sdram controller side, link clock
	input  wire logic                           sd_req,       // access request
	input  wire pin_mux_pkg::sdram_word_t       sd_word,      // pin word
	output logic                                sd_grant,     // word applied
	output logic                                sd_done,      // access ended
	output logic [pin_mux_pkg::DATA_W-1:0]      sd_rdata,     // read data
	// pins
	output logic [pin_mux_pkg::NUM_CS-1:0]      chip_select_n,  // selects
	output logic [pin_mux_pkg::ADDR_W-1:0]      ext_addr,       // address
	output logic                                sdram_addr_bit10_pin,
	output logic                                write_enable_n, // write 0
	output logic                                write1_or_bytemask1_n,
	output logic                                read_strobe_n,  // read / oe
	output logic [pin_mux_pkg::BANK_W-1:0]      bank_select,    // bank
	output logic                                sdram_ras_n,    // row strobe
	output logic                                sdram_cas_n,    // col strobe
	output logic                                sdram_write_en_n,
	output logic                                sdram_clk_en,   // high active
	input  wire logic [pin_mux_pkg::DATA_W-1:0] data_in,        // data pins
	output logic [pin_mux_pkg::DATA_W-1:0]      data_out,       // data drive
	output logic                                data_oe_n,      // low drives
	input  wire logic                           ext_wait_n      // wait pin
);

	// ---------------- link clock domain ----------------

	logic                    lk_rst_s1_reg;
	logic                    lk_rst_reg;
	logic                    grant_s1_reg;
	logic                    grant_s2_reg;
	logic                    grant_s3_reg;
	logic                    lk_req_reg;
	logic                    lk_req_next;
	pin_mux_pkg::sdram_word_t lk_hold_reg;
	pin_mux_pkg::sdram_word_t lk_hold_next;
	logic                    lk_done_reg;
	logic                    lk_done_next;
	logic [pin_mux_pkg::DATA_W-1:0] lk_rdata_reg;
	logic [pin_mux_pkg::DATA_W-1:0] lk_rdata_next;
	logic [pin_mux_pkg::DATA_W-1:0] sd_rd_hold_reg;
	logic                    grant_reg;

	// reset and grant level brought over into the link domain
	always_ff @(posedge link_clock) begin
		lk_rst_s1_reg <= rst;
		lk_rst_reg    <= lk_rst_s1_reg;
		if (lk_rst_reg) begin
			grant_s1_reg <= 1'h0;
			grant_s2_reg <= 1'h0;
			grant_s3_reg <= 1'h0;
		end else begin
			grant_s1_reg <= grant_reg;
			grant_s2_reg <= grant_s1_reg;
			grant_s3_reg <= grant_s2_reg;
		end
	end

	// four phase handshake: capture the word, hold it until released
	always_comb begin
		lk_req_next   = lk_req_reg;
		lk_hold_next  = lk_hold_reg;
		lk_done_next  = 1'h0;
		lk_rdata_next = lk_rdata_reg;
		if (!lk_req_reg && !grant_s2_reg && grant_s3_reg) begin
			lk_done_next  = 1'h1;
			lk_rdata_next = sd_rd_hold_reg;           // stable while grant falls
		end else if (!lk_req_reg && !grant_s2_reg && sd_req) begin
			lk_req_next  = 1'h1;
			lk_hold_next = sd_word;
		end else if (lk_req_reg && grant_s2_reg && !sd_req) begin
			lk_req_next = 1'h0;                      // end of access [RULE_20]
		end
	end

	always_ff @(posedge link_clock) begin
		if (lk_rst_reg) begin
			lk_req_reg   <= 1'h0;
			lk_hold_reg  <= '0;
			lk_done_reg  <= 1'h0;
			lk_rdata_reg <= pin_mux_pkg::DATA_RESET;
		end else begin
			lk_req_reg   <= lk_req_next;
			lk_hold_reg  <= lk_hold_next;
			lk_done_reg  <= lk_done_next;
			lk_rdata_reg <= lk_rdata_next;
		end
	end

	// link side answers
	assign sd_grant = lk_req_reg & grant_s2_reg;
	assign sd_done  = lk_done_reg;
	assign sd_rdata = lk_rdata_reg;

	// ---------------- system clock domain ----------------

	logic                           sd_req_s1_reg;
	logic                           sd_req_s2_reg;
	logic [pin_mux_pkg::DATA_W-1:0] din_s1_reg;
	logic [pin_mux_pkg::DATA_W-1:0] din_s2_reg;
	logic                           wait_s1_reg;
	logic                           wait_s2_reg;

	// pin inputs and the link request pass two flip-flops
	always_ff @(posedge clock) begin
		if (rst) begin
			sd_req_s1_reg <= 1'h0;
			sd_req_s2_reg <= 1'h0;
			din_s1_reg    <= pin_mux_pkg::DATA_RESET;
			din_s2_reg    <= pin_mux_pkg::DATA_RESET;
			wait_s1_reg   <= 1'h1;
			wait_s2_reg   <= 1'h1;
		end else begin
			sd_req_s1_reg <= lk_req_reg;
			sd_req_s2_reg <= sd_req_s1_reg;
			din_s1_reg    <= data_in;
			din_s2_reg    <= din_s1_reg;
			wait_s1_reg   <= ext_wait_n;
			wait_s2_reg   <= wait_s1_reg;
		end
	end

	pin_mux_pkg::owner_t owner_reg;
	pin_mux_pkg::owner_t owner_next;
	logic                refresh_reg;
	logic                refresh_next;
	logic                last_sd_reg;
	logic                last_sd_next;
	logic                grant_next;
	logic [pin_mux_pkg::DATA_W-1:0] sd_rd_hold_next;
	logic                sd_word_req;
	logic                sd_refresh_req;

	// the held word is stable while the synced request is high
	assign sd_word_req    = sd_req_s2_reg & ~lk_hold_reg.refresh;
	assign sd_refresh_req = sd_req_s2_reg & lk_hold_reg.refresh;

	// arbiter: one owner, held until its request drops; alternate on a tie
	always_comb begin
		owner_next      = owner_reg;
		refresh_next    = refresh_reg;
		last_sd_next    = last_sd_reg;
		sd_rd_hold_next = sd_rd_hold_reg;
		case (owner_reg)
			pin_mux_pkg::OWN_NONE: begin
				if (st_req && (!sd_word_req || last_sd_reg)) begin
					owner_next   = pin_mux_pkg::OWN_STATIC;  // [RULE_20]
					last_sd_next = 1'h0;
				end else if (sd_word_req && !refresh_reg) begin
					owner_next   = pin_mux_pkg::OWN_SDRAM;   // [RULE_20]
					last_sd_next = 1'h1;
				end
			end
			pin_mux_pkg::OWN_STATIC: begin
				if (!st_req) begin
					owner_next = pin_mux_pkg::OWN_NONE;      // [RULE_20]
				end
			end
			pin_mux_pkg::OWN_SDRAM: begin
				if (!sd_req_s2_reg) begin
					owner_next      = pin_mux_pkg::OWN_NONE; // [RULE_20]
					sd_rd_hold_next = din_s2_reg;
				end
			end
			default: begin
				owner_next = pin_mux_pkg::OWN_NONE;
			end
		endcase
		// refresh runs beside any static access on sdram only pins
		if (sd_refresh_req && owner_reg != pin_mux_pkg::OWN_SDRAM) begin
			refresh_next = 1'h1;                             // [RULE_19]
		end else if (!sd_req_s2_reg) begin
			refresh_next = 1'h0;
		end
		grant_next = (owner_next == pin_mux_pkg::OWN_SDRAM) | refresh_next;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			owner_reg      <= pin_mux_pkg::OWN_NONE;
			refresh_reg    <= 1'h0;
			last_sd_reg    <= 1'h0;
			grant_reg      <= 1'h0;
			sd_rd_hold_reg <= pin_mux_pkg::DATA_RESET;
		end else begin
			owner_reg      <= owner_next;
			refresh_reg    <= refresh_next;
			last_sd_reg    <= last_sd_next;
			grant_reg      <= grant_next;
			sd_rd_hold_reg <= sd_rd_hold_next;
		end
	end

	// static side answers
	assign st_grant = (owner_reg == pin_mux_pkg::OWN_STATIC);

	logic [pin_mux_pkg::DATA_W-1:0] st_rdata_reg;
	logic [pin_mux_pkg::DATA_W-1:0] st_rdata_next;
	logic                           st_wait_reg;
	logic                           st_wait_next;

	// read data and the low active wait follow the pins to the static side
	always_comb begin
		st_rdata_next = st_rdata_reg;
		if (owner_reg == pin_mux_pkg::OWN_STATIC) begin
			st_rdata_next = din_s2_reg;                      // [RULE_12]
		end
		st_wait_next = wait_s2_reg;                        // [RULE_15]
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			st_rdata_reg <= pin_mux_pkg::DATA_RESET;
			st_wait_reg  <= 1'h1;
		end else begin
			st_rdata_reg <= st_rdata_next;
			st_wait_reg  <= st_wait_next;
		end
	end

	assign st_rdata  = st_rdata_reg;
	assign st_wait_n = st_wait_reg;

	// ---------------- pin routing ----------------

	pin_mux_pkg::pin_out_t pins_reg;
	pin_mux_pkg::pin_out_t pins_next;
	logic                  sd_pins_on;

	assign sd_pins_on = (owner_reg == pin_mux_pkg::OWN_SDRAM) | refresh_reg;

	// address and data hold their last value; selects and strobes go idle
	always_comb begin
		pins_next           = pins_reg;                    // [RULE_18]
		pins_next.cs_n      = pin_mux_pkg::CS_IDLE;        // [RULE_13]
		pins_next.wr0_n     = pin_mux_pkg::STROBE_IDLE;
		pins_next.wr1_n     = pin_mux_pkg::STROBE_IDLE;
		pins_next.rd_n      = pin_mux_pkg::STROBE_IDLE;
		pins_next.ras_n     = pin_mux_pkg::STROBE_IDLE;    // [RULE_16]
		pins_next.cas_n     = pin_mux_pkg::STROBE_IDLE;
		pins_next.we_n      = pin_mux_pkg::STROBE_IDLE;
		pins_next.dout_oe_n = 1'h1;
		if (owner_reg == pin_mux_pkg::OWN_STATIC) begin
			// static owns every select except one lent to sdram
			pins_next.cs_n = st_word.cs_n;                   // [RULE_01] [RULE_03]
			if (cs1_to_sdram) begin
				pins_next.cs_n[pin_mux_pkg::CS_SHARED] = 1'h1; // [RULE_02]
			end
			pins_next.addr      = st_word.addr;      // [RULE_04] [RULE_07] [RULE_10]
			pins_next.wr0_n     = st_word.wr0_n;
			pins_next.wr1_n     = st_word.wr1_n;             // [RULE_11]
			pins_next.rd_n      = st_word.rd_n;
			pins_next.dout      = st_word.wdata;             // [RULE_12]
			pins_next.dout_oe_n = ~st_word.drive;
		end
		if (sd_pins_on) begin
			// sdram only pins, also used by refresh beside a static access
			if (cs1_to_sdram) begin
				pins_next.cs_n[pin_mux_pkg::CS_SHARED] = lk_hold_reg.cs_n; // [RULE_02]
			end
			pins_next.sd_a10 = lk_hold_reg.addr[pin_mux_pkg::SD_A10_BIT]; // [RULE_08]
			pins_next.bank   = lk_hold_reg.bank;             // [RULE_17]
			pins_next.ras_n  = lk_hold_reg.ras_n;            // [RULE_16]
			pins_next.cas_n  = lk_hold_reg.cas_n;
			pins_next.we_n   = lk_hold_reg.we_n;
			pins_next.cke    = lk_hold_reg.cke;              // [RULE_14]
		end
		if (owner_reg == pin_mux_pkg::OWN_SDRAM) begin
			// shared pins only for a full sdram access; others keep value
			pins_next.addr[pin_mux_pkg::SD_LO_PIN_MSB:pin_mux_pkg::SD_LO_PIN_LSB] =
				lk_hold_reg.addr[pin_mux_pkg::SD_LO_BITS-1:0];          // [RULE_07]
			pins_next.addr[pin_mux_pkg::SD_HI_PIN_MSB:pin_mux_pkg::SD_HI_PIN_LSB] =
				lk_hold_reg.addr[pin_mux_pkg::SD_HI_BIT_LSB +:
					pin_mux_pkg::SD_HI_BITS];                          // [RULE_09]
			pins_next.wr1_n     = lk_hold_reg.mask1_n;       // [RULE_11]
			pins_next.dout      = lk_hold_reg.wdata;         // [RULE_12]
			pins_next.dout_oe_n = ~lk_hold_reg.drive;        // [RULE_06]
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			pins_reg <= pin_mux_pkg::PINS_RESET;
		end else begin
			pins_reg <= pins_next;
		end
	end

	// pin drivers, all straight from flip-flops; four devices: four static
	// selects, or three static plus sdram on the lent select
	assign chip_select_n         = pins_reg.cs_n;            // [RULE_05]
	assign ext_addr              = pins_reg.addr;
	assign sdram_addr_bit10_pin  = pins_reg.sd_a10;
	assign write_enable_n        = pins_reg.wr0_n;
	assign write1_or_bytemask1_n = pins_reg.wr1_n;
	assign read_strobe_n         = pins_reg.rd_n;
	assign bank_select           = pins_reg.bank;
	assign sdram_ras_n           = pins_reg.ras_n;
	assign sdram_cas_n           = pins_reg.cas_n;
	assign sdram_write_en_n      = pins_reg.we_n;
	assign sdram_clk_en          = pins_reg.cke;
	assign data_out              = pins_reg.dout;
	assign data_oe_n             = pins_reg.dout_oe_n;

endmodule : external_bus_pin_mux

`default_nettype wire

// file: external_bus_pin_mux_asserts.sv
// pin_mux_checker: routing and timing checks on the pin mux ports
// assumes sd_word stays steady from request until sd_done
`timescale 1ns/10ps
`default_nettype none
module pin_mux_checker (
	input wire logic                              clock,         // sys clock
	input wire logic                              rst,           // sync reset
	input wire logic                              cs1_to_sdram,  // cs1 owner
	input wire logic                              st_req,        // static req
	input wire pin_mux_pkg::static_word_t         st_word,       // static word
	input wire logic                              st_grant,      // static owns
	input wire logic                              st_wait_n,     // synced wait
	input wire pin_mux_pkg::sdram_word_t          sd_word,       // sdram word
	input wire logic [pin_mux_pkg::NUM_CS-1:0]    chip_select_n, // selects
	input wire logic [pin_mux_pkg::ADDR_W-1:0]    ext_addr,      // address
	input wire logic                              sdram_addr_bit10_pin, // a10
	input wire logic                              write_enable_n,    // write 0
	input wire logic                              write1_or_bytemask1_n, // w1
	input wire logic                              read_strobe_n,     // read
	input wire logic [pin_mux_pkg::BANK_W-1:0]    bank_select,       // bank
	input wire logic                              sdram_ras_n,       // row
	input wire logic                              sdram_cas_n,       // column
	input wire logic                              sdram_write_en_n,  // sd we
	input wire logic                              sdram_clk_en,      // cke
	input wire logic [pin_mux_pkg::DATA_W-1:0]    data_out,          // drive
	input wire logic                              data_oe_n,         // oe
	input wire logic                              ext_wait_n         // wait pin
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// static word has been on the pins since the previous cycle
	sequence s_static_held;
		st_grant && $past(st_grant);
	endsequence
	sequence s_static_end;
		$fell(st_grant);
	endsequence
	// static address and selects 0, 2, 3 follow the word one clock late
	property p_st_pins;
		s_static_held |-> ext_addr == $past(st_word.addr)
			&& chip_select_n[0] == $past(st_word.cs_n[0])
			&& chip_select_n[3:2] == $past(st_word.cs_n[3:2]);
	endproperty
	a_st_pins: assert property (p_st_pins)
		else $error("static address or select not routed");
	property p_st_strobes;
		s_static_held |-> write_enable_n == $past(st_word.wr0_n)
			&& write1_or_bytemask1_n == $past(st_word.wr1_n)
			&& read_strobe_n == $past(st_word.rd_n);
	endproperty
	a_st_strobes: assert property (p_st_strobes)
		else $error("static strobes not routed");
	property p_st_data;
		s_static_held |-> data_out == $past(st_word.wdata)
			&& data_oe_n == !$past(st_word.drive);
	endproperty
	a_st_data: assert property (p_st_data)
		else $error("static data not routed");
	property p_cs1_lent;
		s_static_held and $past(cs1_to_sdram) |-> chip_select_n[1];
	endproperty
	a_cs1_lent: assert property (p_cs1_lent)
		else $error("static drove a lent select");
	property p_cs_static_only;
		(chip_select_n | 4'h2) != 4'hF |-> $past(st_grant);
	endproperty
	a_cs_static_only: assert property (p_cs_static_only)
		else $error("static-only select low without static owner");
	// one clock after the grant falls the bus is parked
	property p_release;
		s_static_end |=> chip_select_n == 4'hF && write_enable_n
			&& read_strobe_n && write1_or_bytemask1_n && data_oe_n
			&& $stable(ext_addr);
	endproperty
	a_release: assert property (p_release)
		else $error("bus not parked after static access");
	property p_grant_hold;
		st_grant |=> st_grant == $past(st_req);
	endproperty
	a_grant_hold: assert property (p_grant_hold)
		else $error("static grant not held to request end");
	property p_wait_sync;
		st_wait_n == $past(ext_wait_n, 3);
	endproperty
	a_wait_sync: assert property (p_wait_sync)
		else $error("wait not passed on after three clocks");
	property p_sd_ctrl;
		!sdram_ras_n |-> sdram_addr_bit10_pin == sd_word.addr[10]
			&& bank_select == sd_word.bank && sdram_clk_en == sd_word.cke
			&& sdram_cas_n == sd_word.cas_n
			&& sdram_write_en_n == sd_word.we_n
			&& (!cs1_to_sdram || chip_select_n[1] == sd_word.cs_n);
	endproperty
	a_sd_ctrl: assert property (p_sd_ctrl)
		else $error("sdram control pins not routed");
	property p_sd_addr;
		!sdram_ras_n && !sd_word.refresh |->
			ext_addr[11:2] == sd_word.addr[9:0]
			&& ext_addr[14:13] == sd_word.addr[12:11]
			&& write1_or_bytemask1_n == sd_word.mask1_n
			&& data_oe_n == !sd_word.drive;
	endproperty
	a_sd_addr: assert property (p_sd_addr)
		else $error("sdram address or mask not routed");
	property p_sd_keep;
		!sdram_ras_n |-> $stable(ext_addr[23:15]) && $stable(ext_addr[12]);
	endproperty
	a_sd_keep: assert property (p_sd_keep)
		else $error("sdram moved a static-only address pin");
endmodule : pin_mux_checker
bind external_bus_pin_mux pin_mux_checker pin_mux_checker_inst (.clock,
	.rst, .cs1_to_sdram, .st_req, .st_word, .st_grant, .st_wait_n,
	.sd_word, .chip_select_n, .ext_addr, .sdram_addr_bit10_pin,
	.write_enable_n, .write1_or_bytemask1_n, .read_strobe_n, .bank_select,
	.sdram_ras_n, .sdram_cas_n, .sdram_write_en_n, .sdram_clk_en,
	.data_out, .data_oe_n, .ext_wait_n);
`default_nettype wire

// file: ext_device_model.sv
// ext_device_model: memory devices on the shared pins, behavioural
// assumes pull-ups hold the data bus high when nobody drives it
`timescale 1ns/10ps
`default_nettype none
module ext_device_model #(
	parameter logic [15:0] RD_DATA = 16'hC35A  // data any device returns
) (
	input  wire logic [3:0]  chip_select_n, // selects from the mux
	input  wire logic        read_strobe_n, // static read
	input  wire logic        sdram_cas_n,   // sdram column strobe
	input  wire logic        sdram_write_en_n, // sdram write
	input  wire logic [15:0] data_out,      // mux data drive
	input  wire logic        data_oe_n,     // mux drives when low
	input  wire logic        stall,         // bench asks for a wait
	output logic      [15:0] data_in,       // resolved data bus
	output logic             ext_wait_n     // wait pin, low stretches
);
	logic reading;
	// mux drive wins; a selected device answers static reads, any sdram read is answered; else the bus floats high
	assign reading = (!read_strobe_n && chip_select_n != 4'hF)
		|| (!sdram_cas_n && sdram_write_en_n);
	always_comb begin
		if (!data_oe_n) begin
			data_in = data_out;
		end else if (reading) begin
			data_in = RD_DATA;
		end else begin
			data_in = 16'hFFFF;
		end
	end
	// selected device stretches the access by pulling wait low
	assign ext_wait_n = !(stall && chip_select_n != 4'hF);
endmodule : ext_device_model
`default_nettype wire

// file: tb_external_bus_pin_mux.sv
// tb_external_bus_pin_mux: directed static, sdram and contention tests
// assumes the device model answers every read with 16'hC35A
`timescale 1ns/10ps
`default_nettype none
module tb_external_bus_pin_mux;
	localparam logic [15:0] RD = 16'hC35A;
	logic clock = 0, link_clock = 0, rst = 1, cs1_to_sdram = 0, stall = 0;
	logic st_req = 0, sd_req = 0, st_grant, st_wait_n, sd_grant, sd_done;
	pin_mux_pkg::static_word_t st_word = '0;
	pin_mux_pkg::sdram_word_t  sd_word = '0;
	logic [15:0] st_rdata, sd_rdata, data_in, data_out;
	logic [3:0]  chip_select_n;
	logic [23:0] ext_addr;
	logic [1:0]  bank_select;
	logic sdram_addr_bit10_pin, write_enable_n, write1_or_bytemask1_n;
	logic read_strobe_n, sdram_ras_n, sdram_cas_n, sdram_write_en_n;
	logic sdram_clk_en, data_oe_n, ext_wait_n;
	int n_mismatch = 0, n_checks = 0;
	external_bus_pin_mux external_bus_pin_mux_inst (.clock, .rst,
		.link_clock, .cs1_to_sdram, .st_req, .st_word, .st_grant, .st_rdata,
		.st_wait_n, .sd_req, .sd_word, .sd_grant, .sd_done, .sd_rdata,
		.chip_select_n, .ext_addr, .sdram_addr_bit10_pin, .write_enable_n,
		.write1_or_bytemask1_n, .read_strobe_n, .bank_select, .sdram_ras_n,
		.sdram_cas_n, .sdram_write_en_n, .sdram_clk_en, .data_in, .data_out,
		.data_oe_n, .ext_wait_n);
	ext_device_model ext_device_model_inst (.chip_select_n, .read_strobe_n,
		.sdram_cas_n, .sdram_write_en_n, .data_out, .data_oe_n, .stall,
		.data_in, .ext_wait_n);
	// clocks of the two domains
	always #4 clock = ~clock;
	always #80 link_clock = ~link_clock;
	// compare one observed pin value
	task automatic chk(input string what, input logic [23:0] exp, got);
		n_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : finish_test
	// static access; reads are stretched by the device first
	task automatic st_access(input logic [3:0] cs, input logic [23:0] a,
			input logic wr);
		int i;
		@(posedge clock);
		st_word <= '{cs, a, !wr, !wr, wr, a[15:0], wr};
		st_req <= 1'h1;
		stall <= !wr;
		i = 0;
		while (st_grant !== 1'h1 && i < 50) begin
			@(posedge clock);
			i++;
		end
		repeat (6) @(posedge clock);
		if (!wr) begin
			chk("st_wait_n", 24'h0, 24'(st_wait_n));
			stall <= 1'h0;
			repeat (6) @(posedge clock);
			chk("st_rdata", 24'(RD), 24'(st_rdata));
		end
		chk("cs", 24'(cs | {2'h0, cs1_to_sdram, 1'h0}), 24'(chip_select_n));
		chk("addr", a, ext_addr);
		chk("strobes", 24'({!wr, !wr, wr}),
			24'({write_enable_n, write1_or_bytemask1_n, read_strobe_n}));
		chk("dout", 24'({!wr, a[15:0]}),
			24'({data_oe_n, data_out}));
		st_req <= 1'h0;
		i = 0;
		while (st_grant !== 1'h0 && i < 50) begin
			@(posedge clock);
			i++;
		end
		@(posedge clock);
		chk("idle", 24'h1F, 24'({chip_select_n, data_oe_n}));
		$display("test static cs %h done", cs);
	endtask : st_access
	// sdram access on the link clock; optionally a static request waits
	task automatic sd_access(input logic rf, input logic contend);
		int i;
		@(posedge link_clock);
		sd_word <= '{1'h0, 13'h1ABC, 2'h2, 1'h0, 1'h0, 1'h1, 1'h1, 1'h0,
			16'h0F0F, 1'h0, rf};
		@(posedge link_clock);
		sd_req <= 1'h1;
		i = 0;
		while (sd_grant !== 1'h1 && i < 30) begin
			@(posedge link_clock);
			i++;
		end
		@(posedge link_clock);
		chk("ras a10 bank", 24'h02, 24'({sdram_ras_n, sdram_addr_bit10_pin,
			bank_select}));
		chk("cs1 cke", 24'h1, 24'({chip_select_n[1], sdram_clk_en}));
		if (!rf) begin
			chk("sd addr", 24'h3AF0, 24'({ext_addr[14:13], ext_addr[11:2],
				2'h0}));
		end
		if (contend) begin
			@(posedge clock);
			st_word <= '{4'hE, 24'h123456, 1'h0, 1'h0, 1'h1, 16'h5555, 1'h1};
			st_req <= 1'h1;
			repeat (20) @(posedge clock);
			chk("st_grant held off", 24'h0, 24'(st_grant));
		end
		@(posedge link_clock);
		sd_req <= 1'h0;
		i = 0;
		while (sd_done !== 1'h1 && i < 30) begin
			@(posedge link_clock);
			i++;
		end
		chk("sd_done", 24'h1, 24'(sd_done));
		if (!rf) begin
			chk("sd_rdata", 24'(RD), 24'(sd_rdata));
		end
		if (contend) begin
			repeat (10) @(posedge clock);
			chk("st_grant after", 24'h1, 24'(st_grant));
			st_req <= 1'h0;
			repeat (4) @(posedge clock);
		end
		$display("test sdram refresh %b contend %b done", rf, contend);
	endtask : sd_access
	// watchdog cuts a hang short
	initial begin
		#100000;
		n_mismatch++;
		finish_test();
	end
	// main sequence
	initial begin
		repeat (20) @(posedge clock);
		rst <= 1'h0;
		repeat (4) @(posedge link_clock);
		for (int k = 0; k < 4; k++) begin
			st_access(~(4'h1 << k), 24'hA50000 | 24'(k * 24'h111), 1'h1);
		end
		st_access(4'hB, 24'hFFFFFF, 1'h0);
		cs1_to_sdram <= 1'h1;
		st_access(4'hD, 24'h800001, 1'h1);
		sd_access(1'h0, 1'h0);
		sd_access(1'h1, 1'h0);
		sd_access(1'h0, 1'h1);
		finish_test();
	end
endmodule : tb_external_bus_pin_mux
`default_nettype wire
